//--- sfp_pkg.sv
// Constants and types shared by the synchronous byte-wide FIFO port.
// Assumes a 100 MHz system clock and plain SystemVerilog tools.
package sfp_pkg;

  // ****************************************************************
  // Clocking
  // ****************************************************************
  localparam int unsigned CLOCK_HZ = 100_000_000;
  localparam int unsigned LINK_CLOCK_HZ = 60_000_000;
  localparam int unsigned SYNC_LATENCY = 2;
  localparam int unsigned LINK_HALF_RAW = CLOCK_HZ / (2 * LINK_CLOCK_HZ);
  localparam int unsigned LINK_HALF_CYCLES =
      (LINK_HALF_RAW > SYNC_LATENCY) ? LINK_HALF_RAW : SYNC_LATENCY;

  // ****************************************************************
  // Data path
  // ****************************************************************
  localparam int unsigned DATA_WIDTH = 8;
  localparam int unsigned BUF_DEPTH = 2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic oe_n;
    logic wake_n;
    logic [DATA_WIDTH-1:0] data;
  } sfp_pins_t;

  localparam sfp_pins_t PINS_RESET = 12'hF00;

  typedef enum logic [1:0] {
    ST_OFF = 2'h1,
    ST_SYNC = 2'h2
  } sfp_state_t;

endpackage

//--- sfp_port.sv
// Synchronous byte-wide FIFO port of channel A, with its two-entry buffers.
// Assumes the USB side moves bytes on valid/ready streams in this clock domain.

// ****************************************************************
// Two-entry buffer
// ****************************************************************
module sfp_buffer #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 2
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data,
  output logic [$clog2(DEPTH+1)-1:0] o_count
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  if (DEPTH < 2) begin : g_bad_depth
    $error("Buffer depth must be at least two.");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [CW-1:0] count, next_count;
  logic push, pop;

  always_comb begin
    o_in_ready = (count != CW'(DEPTH));
    o_out_valid = (count != '0);
    o_out_data = mem[rd_ptr];
    o_count = count;
    push = i_in_valid && o_in_ready;
    pop = o_out_valid && i_out_ready;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end
endmodule // sfp_buffer

// ****************************************************************
// FIFO port
// ****************************************************************
// What this block does
// - Sync FIFO mode starts only after port A is configured and a mode command arrives.
// - Second channel is disabled while sync FIFO mode is active.
// - Every byte is sampled or launched on the rising edge of the link clock.
// - Device drives the link clock; far side works synchronously to it.
// - Data bus is input unless sync FIFO mode is active and the far side holds output enable low.
// - Receive flag is low only while a received byte waits to be read.
// - A byte goes out on each edge with receive flag and read strobe low.
// - Transmit flag is low only while a further byte can be accepted.
// - A byte comes in on each edge with transmit flag and write strobe low.
// - Current byte waits on the bus; low read strobe advances it every clock until it rises or the receive flag goes high.
// - Low write strobe captures one byte per clock until it rises or the transmit flag goes high.
// - Wake strobe while suspended with remote wake enabled requests a resume.
// - Wake strobe in normal operation flushes pending transmit data on next IN.
// - Powered flag is low when configured and awake, high otherwise.
module sfp_port
  import sfp_pkg::*;
#(
  parameter int unsigned LINK_HALF = LINK_HALF_CYCLES,
  parameter int unsigned DEPTH = BUF_DEPTH
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_cfg_port_a_fifo,
  input wire logic i_mode_cmd,
  input wire logic i_mode_cmd_sync,
  output logic o_sync_fifo_active,
  output logic o_channel_b_enable,
  input wire logic i_usb_configured,
  input wire logic i_usb_suspended,
  input wire logic i_remote_wake_en,
  output logic o_powered_config_n,
  output logic o_resume_req,
  output logic o_send_now,
  input wire logic i_rx_valid,
  input wire logic [DATA_WIDTH-1:0] i_rx_data,
  output logic o_rx_ready,
  output logic o_tx_valid,
  output logic [DATA_WIDTH-1:0] o_tx_data,
  input wire logic i_tx_ready,
  output logic o_fifo_clock_out,
  output logic o_rx_data_avail_n,
  output logic o_tx_space_avail_n,
  input wire logic i_read_strobe_n,
  input wire logic i_write_strobe_n,
  input wire logic i_bus_output_enable_n,
  input wire logic i_send_now_wake,
  input wire logic [DATA_WIDTH-1:0] i_port_a_data_bus,
  output logic [DATA_WIDTH-1:0] o_port_a_data_bus,
  output logic [DATA_WIDTH-1:0] o_port_a_data_bus_oe
);
  localparam int unsigned DW = (LINK_HALF > 1) ? $clog2(LINK_HALF) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  if (LINK_HALF < SYNC_LATENCY) begin : g_bad_half
    $error("Link half period must cover the input synchroniser.");
  end

  // ****************************************************************
  // Reset release and pin synchronisers
  // ****************************************************************
  logic rst_meta, rst_n;
  sfp_pins_t pin_meta, pin_sync;
  logic wake_prev;

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= PINS_RESET;
      pin_sync <= PINS_RESET;
      wake_prev <= 1'b1;
    end else begin
      pin_meta <= {i_read_strobe_n, i_write_strobe_n, i_bus_output_enable_n,
                   i_send_now_wake, i_port_a_data_bus};
      pin_sync <= pin_meta;
      wake_prev <= pin_sync.wake_n;
    end
  end

  // ****************************************************************
  // Link clock divider
  // ****************************************************************
  logic [DW-1:0] div_cnt, next_div_cnt;
  logic link_clk, next_link_clk, rise_en;

  always_comb begin
    next_div_cnt = div_cnt + 1'b1;
    next_link_clk = link_clk;
    rise_en = 1'b0;
    if (div_cnt == DW'(LINK_HALF - 1)) begin
      next_div_cnt = '0;
      next_link_clk = !link_clk;
      rise_en = !link_clk;
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= '0;
      link_clk <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      link_clk <= next_link_clk;
    end
  end

  assign o_fifo_clock_out = link_clk;

  // ****************************************************************
  // Buffers
  // ****************************************************************
  logic rx_buf_valid, rx_pop, tx_push, tx_in_ready;
  logic [DATA_WIDTH-1:0] rx_buf_data;
  logic [CW-1:0] tx_count;

  sfp_buffer #(.WIDTH(DATA_WIDTH), .DEPTH(DEPTH)) u_rx_buf (
    .i_clock(i_clock),
    .i_rst_n(rst_n),
    .i_in_valid(i_rx_valid),
    .o_in_ready(o_rx_ready),
    .i_in_data(i_rx_data),
    .o_out_valid(rx_buf_valid),
    .i_out_ready(rx_pop),
    .o_out_data(rx_buf_data),
    .o_count()
  );

  sfp_buffer #(.WIDTH(DATA_WIDTH), .DEPTH(DEPTH)) u_tx_buf (
    .i_clock(i_clock),
    .i_rst_n(rst_n),
    .i_in_valid(tx_push),
    .o_in_ready(tx_in_ready),
    .i_in_data(pin_sync.data),
    .o_out_valid(o_tx_valid),
    .i_out_ready(i_tx_ready),
    .o_out_data(o_tx_data),
    .o_count(tx_count)
  );

  // ****************************************************************
  // Mode, flags and data
  // ****************************************************************
  sfp_state_t state, next_state;
  logic active, rx_take, rx_load;
  logic rx_avail_n, next_rx_avail_n, tx_avail_n, next_tx_avail_n;
  logic [DATA_WIDTH-1:0] shown, next_shown;
  logic [CW:0] tx_fill;

  always_comb begin
    active = (state == ST_SYNC);
    next_state = state;
    case (state)
      ST_OFF: begin
        if (i_mode_cmd && i_mode_cmd_sync && i_cfg_port_a_fifo) begin
          next_state = ST_SYNC;
        end
      end
      ST_SYNC: begin
        if ((i_mode_cmd && !i_mode_cmd_sync) || !i_cfg_port_a_fifo) begin
          next_state = ST_OFF;
        end
      end
      default: next_state = ST_OFF;
    endcase
    rx_take = rise_en && active && !rx_avail_n && !pin_sync.rd_n;
    rx_load = rise_en && active && (rx_take || rx_avail_n);
    rx_pop = rx_load && rx_buf_valid;
    tx_push = rise_en && active && !tx_avail_n && !pin_sync.wr_n;
    tx_fill = (CW + 1)'(tx_count) + (CW + 1)'(tx_push);
    next_shown = rx_pop ? rx_buf_data : shown;
    next_rx_avail_n = rx_avail_n;
    next_tx_avail_n = tx_avail_n;
    if (!active) begin
      next_rx_avail_n = 1'b1;
      next_tx_avail_n = 1'b1;
    end else if (rise_en) begin
      if (rx_load) begin
        next_rx_avail_n = !rx_buf_valid;
      end
      next_tx_avail_n = (tx_fill >= (CW + 1)'(DEPTH));
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_OFF;
      rx_avail_n <= 1'b1;
      tx_avail_n <= 1'b1;
      shown <= '0;
    end else begin
      state <= next_state;
      rx_avail_n <= next_rx_avail_n;
      tx_avail_n <= next_tx_avail_n;
      shown <= next_shown;
    end
  end

  assign o_sync_fifo_active = active;
  assign o_channel_b_enable = !active;
  assign o_rx_data_avail_n = rx_avail_n;
  assign o_tx_space_avail_n = tx_avail_n;
  assign o_port_a_data_bus = shown;
  assign o_port_a_data_bus_oe = {DATA_WIDTH{active && !pin_sync.oe_n}};

  // ****************************************************************
  // Power flag and wake strobe
  // ****************************************************************
  logic pwr_n, next_pwr_n, resume, next_resume, flush, next_flush, wake_fall;

  always_comb begin
    wake_fall = wake_prev && !pin_sync.wake_n;
    next_pwr_n = !(i_usb_configured && !i_usb_suspended);
    next_resume = wake_fall && i_usb_suspended && i_remote_wake_en;
    next_flush = wake_fall && !pwr_n;
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      pwr_n <= 1'b1;
      resume <= 1'b0;
      flush <= 1'b0;
    end else begin
      pwr_n <= next_pwr_n;
      resume <= next_resume;
      flush <= next_flush;
    end
  end

  assign o_powered_config_n = pwr_n;
  assign o_resume_req = resume;
  assign o_send_now = flush;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!rst_n);

  mode_entry_a: assert property ($rose(active) |->
    $past(i_mode_cmd && i_mode_cmd_sync && i_cfg_port_a_fifo))
    else $error("Sync mode entered without command.");
  chan_b_off_a: assert property (active |-> !o_channel_b_enable)
    else $error("Second channel enabled in sync mode.");
  edge_launch_a: assert property ($changed(o_port_a_data_bus) |-> $past(rise_en))
    else $error("Data changed off the rising edge.");
  clock_rise_a: assert property (rise_en |=> o_fifo_clock_out ##1 o_fifo_clock_out)
    else $error("Link clock high phase too short.");
  bus_drive_a: assert property (o_port_a_data_bus_oe[0] |-> active && !pin_sync.oe_n)
    else $error("Bus driven without output enable.");
  rx_flag_a: assert property (rise_en && !active |=> o_rx_data_avail_n)
    else $error("Receive flag low outside sync mode.");
  rx_stop_a: assert property (rx_take && !rx_buf_valid |=> o_rx_data_avail_n)
    else $error("Read burst ran past the last byte.");
  rx_next_a: assert property (rx_take && rx_buf_valid |=>
    o_port_a_data_bus == $past(rx_buf_data) && !o_rx_data_avail_n)
    else $error("Read burst did not advance.");
  tx_room_a: assert property (tx_push |-> tx_in_ready)
    else $error("Write accepted with no room.");
  tx_full_a: assert property (tx_count == CW'(DEPTH) |-> o_tx_space_avail_n)
    else $error("Transmit flag low while full.");
  resume_req_a: assert property (wake_fall && i_usb_suspended && i_remote_wake_en
    |=> o_resume_req ##1 !o_resume_req)
    else $error("Wake strobe gave no resume pulse.");
  send_now_a: assert property (wake_fall && !o_powered_config_n |=> o_send_now)
    else $error("Wake strobe gave no flush pulse.");
  power_flag_a: assert property (i_usb_configured && !i_usb_suspended
    |=> !o_powered_config_n)
    else $error("Powered flag high while configured.");
endmodule // sfp_port

//--- sfp_far_model.sv
// Behavioural model of the far-side logic on the synchronous FIFO port.
// Assumes the bench resolves the shared data bus and sets the go levels.
module sfp_far_model
  import sfp_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_link_clock,
  input wire logic i_rx_avail_n,
  input wire logic i_tx_space_n,
  input wire logic [DATA_WIDTH-1:0] i_bus,
  input wire logic [DATA_WIDTH-1:0] i_wr_byte,
  input wire logic i_rd_go,
  input wire logic i_wr_go,
  input wire logic i_wake_go,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic o_oe_n,
  output logic o_wake_n,
  output logic o_drive,
  output logic [DATA_WIDTH-1:0] o_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic rx_n;
  logic tx_n;
  logic [DATA_WIDTH-1:0] bus;
  logic [DATA_WIDTH-1:0] got_q[$];
  logic [DATA_WIDTH-1:0] put_q[$];

  initial begin
    {o_rd_n, o_wr_n, o_oe_n, o_wake_n, o_drive} = 5'h1E;
    o_data = 8'h00;
  end

  // Takes the device pins as they stand just before each link rise.
  always @(negedge i_clock) begin
    rx_n = i_rx_avail_n;
    tx_n = i_tx_space_n;
    bus = i_bus;
  end

  // Moves bytes on link rises and changes the strobes just after them.
  always @(posedge i_link_clock) begin
    if (!o_rd_n && !rx_n) got_q.push_back(bus);
    if (!o_wr_n && !tx_n) put_q.push_back(o_data);
    #1;
    if (o_wr_n || !tx_n) o_data = i_wr_byte;
    o_rd_n = !(i_rd_go && !o_oe_n);
    o_oe_n = !i_rd_go;
    o_wr_n = !(i_wr_go && !i_rd_go);
    o_drive = !o_wr_n;
    o_wake_n = !i_wake_go;
  end
endmodule // sfp_far_model

//--- tb_sfp_port.sv
// Self-checking bench for the synchronous FIFO port against a queue model.
// Assumes the far-side model file and the design package are compiled first.
module tb_sfp_port
  import sfp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned TB_LINK_HALF = 4;
  logic clk = 0, rstn = 0, cfg = 0, cmd = 0, cmd_sync = 0, conf = 0, susp = 0, rwe = 0;
  logic rx_valid = 0, tx_ready = 0, rd_go = 0, wr_go = 0, wake_go = 0, rx_on = 0, tx_on = 0;
  logic act, chb, pwr_n, resume, send_now, rx_ready, tx_valid, lclk, rxf_n, txe_n, acc;
  logic rd_n, wr_n, oe_n, wake_n, far_drive;
  logic [DATA_WIDTH-1:0] rx_data = 0, wr_byte = 0, bus_last = 0;
  logic [DATA_WIDTH-1:0] tx_data, dout, doe, far_data, bus_w;
  logic [DATA_WIDTH-1:0] rx_sent[$];
  logic [DATA_WIDTH-1:0] tx_got[$];
  int seed = 32'h79b4;
  int n_fail = 0, check_count = 0, cyc = 0, n_res = 0, n_snd = 0, oe_hi = 0, oe_lo = 0, r = 0;

  always #5 clk = ~clk;
  assign bus_w = doe[0] ? dout : (far_drive ? far_data : ~bus_last);

  sfp_port #(.LINK_HALF(TB_LINK_HALF), .DEPTH(BUF_DEPTH)) sfp_port_inst (
    .i_clock(clk), .i_resetn(rstn), .i_cfg_port_a_fifo(cfg), .i_mode_cmd(cmd),
    .i_mode_cmd_sync(cmd_sync), .o_sync_fifo_active(act), .o_channel_b_enable(chb),
    .i_usb_configured(conf), .i_usb_suspended(susp), .i_remote_wake_en(rwe),
    .o_powered_config_n(pwr_n), .o_resume_req(resume), .o_send_now(send_now),
    .i_rx_valid(rx_valid), .i_rx_data(rx_data), .o_rx_ready(rx_ready),
    .o_tx_valid(tx_valid), .o_tx_data(tx_data), .i_tx_ready(tx_ready),
    .o_fifo_clock_out(lclk), .o_rx_data_avail_n(rxf_n), .o_tx_space_avail_n(txe_n),
    .i_read_strobe_n(rd_n), .i_write_strobe_n(wr_n), .i_bus_output_enable_n(oe_n),
    .i_send_now_wake(wake_n), .i_port_a_data_bus(bus_w), .o_port_a_data_bus(dout),
    .o_port_a_data_bus_oe(doe));

  sfp_far_model sfp_far_model_inst (
    .i_clock(clk), .i_link_clock(lclk), .i_rx_avail_n(rxf_n), .i_tx_space_n(txe_n),
    .i_bus(bus_w), .i_wr_byte(wr_byte), .i_rd_go(rd_go), .i_wr_go(wr_go),
    .i_wake_go(wake_go), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_oe_n(oe_n),
    .o_wake_n(wake_n), .o_drive(far_drive), .o_data(far_data));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    if (n_fail == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic rises(input int n);
    repeat (n) @(posedge lclk);
    #2;
  endtask

  task automatic pulse_cmd(input logic s);
    @(posedge clk) #1 cmd = 1;
    cmd_sync = s;
    @(posedge clk) #1 cmd = 0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic wake_strobe();
    wake_go = 1;
    rises(2);
    wake_go = 0;
    rises(4);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      summarize();
    end
  end

  // Streams, pulse counters and bus-enable watch.
  always @(posedge clk) begin
    bus_last <= bus_w;
    n_res += (resume === 1'b1);
    n_snd += (send_now === 1'b1);
    acc = rx_valid && rx_ready;
    if (acc) rx_sent.push_back(rx_data);
    if (tx_valid && tx_ready) tx_got.push_back(tx_data);
    oe_hi = oe_n ? oe_hi + 1 : 0;
    oe_lo = oe_n ? 0 : oe_lo + 1;
    #1;
    if (oe_hi > 3) chk("bus_oe_off", 8'h00, doe);
    if (oe_lo > 3 && act) chk("bus_oe_on", 8'hFF, doe);
    r = $random(seed);
    if (!rx_valid || acc) begin
      rx_valid = rx_on & r[0];
      rx_data = r[15:8];
    end
    tx_ready = tx_on & r[1];
    wr_byte = r[23:16];
  end

  initial begin
    repeat (2) @(posedge clk);
    #1 rstn = 1;
    repeat (3) @(posedge clk);
    #1;
    chk("reset_outs", 8'h1B, {3'h0, chb, pwr_n, act, rxf_n, txe_n});
    pulse_cmd(1'b1);
    chk("refused_mode", 8'h00, {7'h00, act});
    cfg = 1;
    pulse_cmd(1'b1);
    chk("mode_on", 8'h02, {6'h00, act, chb});
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) #1 {conf, susp} = i[1:0];
      repeat (2) @(posedge clk);
      #1 chk("powered_n", {7'h00, !(conf && !susp)}, {7'h00, pwr_n});
    end
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) #1 rwe = i[0];
      wake_strobe();
      chk("resume_req", i[7:0], n_res[7:0]);
    end
    @(posedge clk) #1 susp = 0;
    wake_strobe();
    chk("send_now", 8'h01, n_snd[7:0]);
    rx_on = 1;
    repeat (60) begin
      rd_go = r[5];
      rises(1);
    end
    rx_on = 0;
    rd_go = 1;
    rises(12);
    rd_go = 0;
    rises(2);
    chk("rx_empty", 8'h01, {7'h00, rxf_n});
    chk("rx_count", 8'(rx_sent.size()), 8'(sfp_far_model_inst.got_q.size()));
    foreach (rx_sent[i]) chk("rx_byte", rx_sent[i], sfp_far_model_inst.got_q[i]);
    wr_go = 1;
    rises(10);
    chk("tx_full", 8'h01, {7'h00, txe_n});
    chk("tx_held", 8'(BUF_DEPTH), 8'(sfp_far_model_inst.put_q.size()));
    tx_on = 1;
    repeat (60) begin
      wr_go = r[6];
      rises(1);
    end
    wr_go = 0;
    rises(8);
    chk("tx_count", 8'(sfp_far_model_inst.put_q.size()), 8'(tx_got.size()));
    foreach (tx_got[i]) chk("tx_byte", sfp_far_model_inst.put_q[i], tx_got[i]);
    pulse_cmd(1'b0);
    rises(1);
    chk("mode_off", 8'h07, {4'h0, act, chb, rxf_n, txe_n});
    pulse_cmd(1'b1);
    chk("mode_again", 8'h02, {6'h00, act, chb});
    @(posedge clk) #1 cfg = 0;
    repeat (2) @(posedge clk);
    #1 chk("cfg_drop", 8'h01, {6'h00, act, chb});
    summarize();
  end
endmodule // tb_sfp_port
